// >>> hdl/wdcu_pkg.sv
// Constants, types and timeout tables for the watchdog configuration and unlock block
// ****************************************************************
// Operation
// - Two-bit mode field picks watchdog supervision mode
// - Two-bit field sets tolerated missed refreshes
// - Four-bit code picks refresh timeout min/max
// - Three-bit code picks window error timeout
// - Gate role bit sets delay and undervoltage detect
// - Fault pin drives fault low or 50 Hz
// - Question register holds six bits, resets zero
// - Wrong key word restarts sequence from first
// - Third key word selects the protected action
// - Key register write-only, key field resets zero
// ****************************************************************
package wdcu_pkg;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] WDCU_OFS_CFG0 = 8'h08; // Watchdog config primary
   localparam logic [7:0] WDCU_OFS_CFG1 = 8'h09; // Watchdog config secondary
   localparam logic [7:0] WDCU_OFS_QA = 8'h0A; // Question and answer value
   localparam logic [7:0] WDCU_OFS_KEY = 8'h0B; // Unlock sequence word, write-only
   localparam logic [7:0] WDCU_OFS_STAT = 8'h10; // Event status, write one to clear
   localparam logic [7:0] WDCU_OFS_MASK = 8'h11; // Event interrupt mask
   localparam logic [7:0] WDCU_OFS_STATE = 8'h12; // Live block state, read-only

   // Reset values
   localparam logic [7:0] WDCU_RST_CFG0 = 8'h00;
   localparam logic [7:0] WDCU_RST_CFG1 = 8'h00;
   localparam logic [5:0] WDCU_RST_QA = 6'h00;
   localparam logic [7:0] WDCU_RST_KEY = 8'h00;
   localparam logic [3:0] WDCU_RST_MASK = 4'h0;

   // Status and mask bit positions
   localparam int WDCU_EV_KEY_OK = 0; // Full key sequence accepted
   localparam int WDCU_EV_KEY_BAD = 1; // Key word mismatch
   localparam int WDCU_EV_MISS = 2; // Refresh missed (early or late)
   localparam int WDCU_EV_FAULT = 3; // Miss allowance exhausted

   // Unlock words
   localparam logic [7:0] WDCU_KEY_FIRST = 8'hD3;
   localparam logic [7:0] WDCU_KEY_SECOND = 8'h33;
   localparam logic [7:0] WDCU_KEY_FLASH = 8'hCC;
   localparam logic [7:0] WDCU_KEY_CONFIG = 8'hCD;
   localparam logic [7:0] WDCU_KEY_RESTART = 8'hCE;
   localparam logic [7:0] WDCU_KEY_DISABLE = 8'hCF;

   // ****************************************************************
   // Timing: timeouts and delays are counted in 0.5 ms ticks
   // ****************************************************************
   localparam int WDCU_CLK_PERIOD_NS = 40; // 25 MHz core clock
   localparam int WDCU_TICK_TIME_NS = 500000; // 0.5 ms tick
   localparam int WDCU_TICK_CYCLES = WDCU_TICK_TIME_NS / WDCU_CLK_PERIOD_NS;
   localparam logic [4:0] WDCU_GATE_DLY_ISO = 5'd20; // 10 ms in ticks
   localparam logic [4:0] WDCU_GATE_DLY_BAT = 5'd3; // 1.5 ms in ticks
   localparam logic [4:0] WDCU_SLOW_HALF = 5'd20; // 10 ms half period of 50 Hz

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      WDCU_MODE_WAIT = 2'd0, // Waiting for configuration
      WDCU_MODE_WIN = 2'd1, // Window only
      WDCU_MODE_QA = 2'd2, // Question and answer only
      WDCU_MODE_BOTH = 2'd3 // Both checks
   } wdcu_mode_e;

   typedef enum logic [1:0] {
      WDCU_KEY_IDLE = 2'b00, // Expecting first word
      WDCU_KEY_GOT1 = 2'b01, // First word seen
      WDCU_KEY_GOT2 = 2'b11 // Second word seen
   } wdcu_key_e;

   typedef struct packed {
      wdcu_mode_e mode; // [7:6]
      logic [1:0] allow; // [5:4]
      logic [3:0] timer; // [3:0]
   } wdcu_cfg0_s;

   typedef struct packed {
      logic [1:0] unused; // [7:6] read as zero
      logic gate_role; // [5]
      logic fault_fn; // [4]
      logic [2:0] win; // [3:1]
      logic dith_off; // [0]
   } wdcu_cfg1_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } wdcu_bus_s;

   // ****************************************************************
   // Tables
   // ****************************************************************
   // Refresh timeout minimum in ticks; maximum is twice this
   function automatic logic [9:0] wdcu_refr_min(input logic [3:0] code);
      logic [9:0] t;
      t = 10'd0;
      case (code)
         4'h0: t = 10'd1;
         4'h1: t = 10'd2;
         4'h2: t = 10'd4;
         4'h3: t = 10'd8;
         4'h4: t = 10'd16;
         4'h5: t = 10'd24;
         4'h6: t = 10'd32;
         4'h7: t = 10'd48;
         4'h8: t = 10'd64;
         4'h9: t = 10'd80;
         4'hA: t = 10'd128;
         4'hB: t = 10'd144;
         4'hC: t = 10'd160;
         4'hD: t = 10'd192;
         4'hE: t = 10'd256;
         default: t = 10'd288;
      endcase
      return t;
   endfunction

   // Window error timeout maximum in ticks
   function automatic logic [9:0] wdcu_win_max(input logic [2:0] code);
      logic [9:0] t;
      t = 10'd0;
      case (code)
         3'd0: t = 10'd8;
         3'd1: t = 10'd16;
         3'd2: t = 10'd32;
         3'd3: t = 10'd64;
         3'd4: t = 10'd84;
         3'd5: t = 10'd128;
         3'd6: t = 10'd160;
         default: t = 10'd200;
      endcase
      return t;
   endfunction

   // Misses tolerated: 0, 1, 3 or 7
   function automatic logic [2:0] wdcu_allow(input logic [1:0] code);
      return 3'((4'd1 << code) - 4'd1);
   endfunction

endpackage

// >>> hdl/wdcu_ticker.sv
// Prescaler that turns the core clock into 0.5 ms ticks
`timescale 1ns/1ps
module wdcu_ticker #(
   parameter int unsigned TICK_CYCLES = 12500
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);
   import wdcu_pkg::*;

   logic [15:0] cnt_q; // Cycles into the current tick

   // Free-running divide; tick is one cycle wide
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q == 16'(TICK_CYCLES - 1)) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   assign tick = (cnt_q == 16'(TICK_CYCLES - 1));

endmodule // wdcu_ticker

// >>> hdl/wdcu_top.sv
// Watchdog configuration registers, supervision timers and unlock sequence
`timescale 1ns/1ps
module wdcu_top #(
   parameter int unsigned TICK_CYCLES = wdcu_pkg::WDCU_TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire wdcu_pkg::wdcu_bus_s bus,
   output logic [7:0] rdata,
   input wire logic refresh_pulse,
   input wire logic ext_fault,
   input wire logic phase_gate_enable,
   output logic phase_gate_drive,
   output logic source_node_undervoltage_detect,
   output logic fault_flag_pin,
   output logic spread_spectrum_on,
   output logic wd_reset_out,
   output logic flash_mode,
   output logic config_mode,
   output logic irq
);
   import wdcu_pkg::*;

   // ****************************************************************
   // Declarations
   // ****************************************************************
   wdcu_cfg0_s cfg0_q; // Mode, allowance, refresh timer
   wdcu_cfg1_s cfg1_q; // Gate role, fault pin, window timer, dither
   logic [5:0] qa_q; // Question value
   logic [7:0] key_q; // Last key word, never readable
   wdcu_key_e key_st_q; // Unlock progress
   logic [3:0] stat_q; // Sticky events
   logic [3:0] mask_q; // Interrupt enables
   logic [7:0] rdata_q; // Read data, valid one cycle after strobe
   logic tick; // 0.5 ms pulse
   logic [9:0] tcnt_q; // Ticks since last refresh
   logic [2:0] miss_q; // Misses so far
   logic fault_q; // Watchdog fault latched
   logic disabled_q; // Debug disable
   logic flash_q;
   logic config_q;
   logic [9:0] err_q; // Remaining reset pulse ticks
   logic [4:0] gcnt_q; // Gate delay ticks
   logic gate_q;
   logic [4:0] scnt_q; // Slow clock half period ticks
   logic slow_q;
   logic pin_q;
   logic wr_cfg0, wr_cfg1, wr_qa, wr_key, wr_stat, wr_mask;
   logic key_ok, key_bad, act_restart, act_disable;
   logic wd_active, refresh_evt, early, late, miss, overflow;
   logic [9:0] refr_min, refr_max;
   logic [4:0] gate_dly;
   logic [3:0] ev;

   // ****************************************************************
   // Register bus decode
   // ****************************************************************
   assign wr_cfg0 = bus.wr && (bus.addr == WDCU_OFS_CFG0);
   assign wr_cfg1 = bus.wr && (bus.addr == WDCU_OFS_CFG1);
   assign wr_qa = bus.wr && (bus.addr == WDCU_OFS_QA);
   assign wr_key = bus.wr && (bus.addr == WDCU_OFS_KEY);
   assign wr_stat = bus.wr && (bus.addr == WDCU_OFS_STAT);
   assign wr_mask = bus.wr && (bus.addr == WDCU_OFS_MASK);

   // Configuration registers; unused bits store zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg0_q <= wdcu_cfg0_s'(WDCU_RST_CFG0);
         cfg1_q <= wdcu_cfg1_s'(WDCU_RST_CFG1);
      end else begin
         if (wr_cfg0) begin
            cfg0_q <= wdcu_cfg0_s'(bus.wdata);
         end
         if (wr_cfg1) begin
            cfg1_q <= wdcu_cfg1_s'({2'b00, bus.wdata[5:0]});
         end
      end
   end

   // Question register, full read/write
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         qa_q <= WDCU_RST_QA;
      end else if (wr_qa) begin
         qa_q <= bus.wdata[5:0];
      end
   end

   // Read port; the key word is deliberately never returned
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         case (bus.addr)
            WDCU_OFS_CFG0: rdata_q <= cfg0_q;
            WDCU_OFS_CFG1: rdata_q <= cfg1_q;
            WDCU_OFS_QA: rdata_q <= {2'b00, qa_q};
            WDCU_OFS_STAT: rdata_q <= {4'h0, stat_q};
            WDCU_OFS_MASK: rdata_q <= {4'h0, mask_q};
            WDCU_OFS_STATE: rdata_q <= {key_st_q, miss_q, fault_q, disabled_q, config_q};
            default: rdata_q <= 8'h00; // Key register and unmapped
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end
   assign rdata = rdata_q;

   // ****************************************************************
   // Unlock sequence
   // ****************************************************************
   // Holds the last word written; reset clears it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         key_q <= WDCU_RST_KEY;
      end else if (wr_key) begin
         key_q <= bus.wdata;
      end
   end

   // Any wrong word drops progress back to the first word
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         key_st_q <= WDCU_KEY_IDLE;
      end else if (wr_key) begin
         case (key_st_q)
            WDCU_KEY_IDLE: key_st_q <= (bus.wdata == WDCU_KEY_FIRST) ? WDCU_KEY_GOT1
                                                                     : WDCU_KEY_IDLE;
            WDCU_KEY_GOT1: key_st_q <= (bus.wdata == WDCU_KEY_SECOND) ? WDCU_KEY_GOT2
                                                                      : WDCU_KEY_IDLE;
            default: key_st_q <= WDCU_KEY_IDLE; // Third word always ends the sequence
         endcase
      end
   end

   // Third word: top six bits shared by all four actions
   assign key_ok = wr_key && (key_st_q == WDCU_KEY_GOT2)
                   && (bus.wdata[7:2] == WDCU_KEY_FLASH[7:2]);
   assign key_bad = wr_key && !key_ok && !((key_st_q == WDCU_KEY_IDLE)
                   && (bus.wdata == WDCU_KEY_FIRST))
                   && !((key_st_q == WDCU_KEY_GOT1) && (bus.wdata == WDCU_KEY_SECOND));
   assign act_restart = key_ok && (bus.wdata == WDCU_KEY_RESTART);
   assign act_disable = key_ok && (bus.wdata == WDCU_KEY_DISABLE);

   // Flash and config flags stay until reset; there is no documented exit; restart key clears disable
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flash_q <= 1'b0;
         config_q <= 1'b0;
         disabled_q <= 1'b0;
      end else begin
         if (key_ok && (bus.wdata == WDCU_KEY_FLASH)) begin
            flash_q <= 1'b1;
         end
         if (key_ok && (bus.wdata == WDCU_KEY_CONFIG)) begin
            config_q <= 1'b1;
         end
         if (act_disable) begin
            disabled_q <= 1'b1;
         end else if (act_restart) begin
            disabled_q <= 1'b0;
         end
      end
   end
   assign flash_mode = flash_q;
   assign config_mode = config_q;

   // ****************************************************************
   // Supervision timers
   // ****************************************************************
   wdcu_ticker #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_ticker (
      .clk(clk),
      .rst_n(rst_n),
      .tick(tick)
   );

   assign refr_min = wdcu_refr_min(cfg0_q.timer);
   assign refr_max = {refr_min[8:0], 1'b0};
   assign wd_active = (cfg0_q.mode != WDCU_MODE_WAIT) && !disabled_q && !fault_q;
   // Window refreshes come from the pin, answers from the question register
   assign refresh_evt = wd_active && ((cfg0_q.mode[0] && refresh_pulse)
                        || (cfg0_q.mode[1] && wr_qa));
   // Only the window check penalises a refresh that comes too soon
   assign early = refresh_evt && cfg0_q.mode[0] && (tcnt_q < refr_min);
   assign late = wd_active && (tcnt_q >= refr_max);
   assign miss = early || late;
   assign overflow = miss && (miss_q >= wdcu_allow(cfg0_q.allow));

   // Tick count since the last refresh, early or not, or late miss
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tcnt_q <= 10'd0;
      end else if (!wd_active || refresh_evt || late || act_restart) begin
         tcnt_q <= 10'd0;
      end else if (tick) begin
         tcnt_q <= tcnt_q + 10'd1;
      end
   end

   // Miss counter and fault latch; only the restart key clears them
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         miss_q <= 3'd0;
         fault_q <= 1'b0;
      end else if (act_restart) begin
         miss_q <= 3'd0;
         fault_q <= 1'b0;
      end else if (overflow) begin
         fault_q <= 1'b1;
      end else if (miss) begin
         miss_q <= miss_q + 3'd1;
      end
   end

   // Reset pulse lasts the window error timeout selected by the win field
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         err_q <= 10'd0;
      end else if (overflow) begin
         err_q <= wdcu_win_max(cfg1_q.win);
      end else if (tick && (err_q != 10'd0)) begin
         err_q <= err_q - 10'd1;
      end
   end
   assign wd_reset_out = (err_q != 10'd0);

   // ****************************************************************
   // Auxiliary outputs
   // ****************************************************************
   assign gate_dly = cfg1_q.gate_role ? WDCU_GATE_DLY_BAT : WDCU_GATE_DLY_ISO;

   // Gate follows its enable after the role-dependent delay, both edges
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         gcnt_q <= 5'd0;
         gate_q <= 1'b0;
      end else if (phase_gate_enable == gate_q) begin
         gcnt_q <= 5'd0;
      end else if (tick) begin
         if (gcnt_q + 5'd1 >= gate_dly) begin
            gate_q <= phase_gate_enable;
            gcnt_q <= 5'd0;
         end else begin
            gcnt_q <= gcnt_q + 5'd1;
         end
      end
   end
   assign phase_gate_drive = gate_q;
   assign source_node_undervoltage_detect = cfg1_q.gate_role;

   // Slow square wave, 20 ms period
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         scnt_q <= 5'd0;
         slow_q <= 1'b0;
      end else if (tick) begin
         if (scnt_q == WDCU_SLOW_HALF - 5'd1) begin
            scnt_q <= 5'd0;
            slow_q <= ~slow_q;
         end else begin
            scnt_q <= scnt_q + 5'd1;
         end
      end
   end

   // Pin is registered so it never glitches between sources
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_q <= 1'b1;
      end else if (cfg1_q.fault_fn) begin
         pin_q <= slow_q;
      end else begin
         pin_q <= !(fault_q || ext_fault);
      end
   end
   assign fault_flag_pin = pin_q;
   assign spread_spectrum_on = !cfg1_q.dith_off;

   // ****************************************************************
   // Events and interrupt
   // ****************************************************************
   assign ev = {overflow, miss, key_bad, key_ok};

   // Set beats clear so an event in the clearing cycle survives
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stat_q <= 4'h0;
         mask_q <= WDCU_RST_MASK;
      end else begin
         stat_q <= (stat_q & ~(wr_stat ? bus.wdata[3:0] : 4'h0)) | ev;
         if (wr_mask) begin
            mask_q <= bus.wdata[3:0];
         end
      end
   end
   assign irq = |(stat_q & mask_q);

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_first_two;
      wr_key && bus.wdata == WDCU_KEY_FIRST && key_st_q == WDCU_KEY_IDLE
      ##1 wr_key && bus.wdata == WDCU_KEY_SECOND;
   endsequence

   chk_mode_write: assert property (wr_cfg0 |=> cfg0_q.mode == $past(bus.wdata[7:6]))
      else $error("mode field not stored");
   chk_fault_allow: assert property ($rose(fault_q) |-> $past(miss_q) == $past(wdcu_allow(cfg0_q.allow)))
      else $error("fault raised at wrong miss count");
   chk_refresh_late: assert property (late |=> tcnt_q == 10'd0 && miss_q + fault_q != 4'd0)
      else $error("late refresh not handled");
   chk_err_pulse: assert property (overflow |=> wd_reset_out && err_q == $past(wdcu_win_max(cfg1_q.win)))
      else $error("reset pulse length wrong");
   chk_gate_role: assert property (source_node_undervoltage_detect == cfg1_q.gate_role
      && (phase_gate_enable == gate_q || gcnt_q < gate_dly))
      else $error("gate role outputs wrong");
   chk_fault_pin: assert property (!cfg1_q.fault_fn && fault_q ##1 !cfg1_q.fault_fn |-> !fault_flag_pin)
      else $error("fault pin not low on fault");
   chk_qa_readback: assert property (wr_qa ##1 bus.rd && bus.addr == WDCU_OFS_QA |=> rdata == {2'b00, $past(bus.wdata[5:0], 2)})
      else $error("question readback wrong");
   chk_key_reject: assert property (wr_key && !key_ok && key_st_q != WDCU_KEY_IDLE && bus.wdata != WDCU_KEY_SECOND |=> key_st_q == WDCU_KEY_IDLE)
      else $error("bad key word kept progress");
   chk_key_action: assert property (s_first_two ##1 wr_key && bus.wdata == WDCU_KEY_CONFIG |=> config_q)
      else $error("config unlock failed");
   chk_key_hidden: assert property (bus.rd && bus.addr == WDCU_OFS_KEY |=> rdata == 8'h00)
      else $error("key register readable");
   chk_tick_count: assert property (wd_active && tick && !refresh_evt && !late && !act_restart |=> tcnt_q == $past(tcnt_q) + 10'd1)
      else $error("tick count stalled");
   chk_dither_off: assert property (wr_cfg1 |=> spread_spectrum_on == !$past(bus.wdata[0]))
      else $error("dither control wrong");

endmodule // wdcu_top

// >>> test/wdcu_host.sv
// Host partner model: sends watchdog refresh pulses at a set spacing
`timescale 1ns/1ps
module wdcu_host (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [7:0] gap,
   output logic refresh_pulse
);
   logic [7:0] cnt_q; // Cycles since the last pulse
   // One pulse every gap+1 cycles; the bench picks gap inside the open window, or too short in t_qa
   always_ff @(posedge clk) begin
      if (!rst_n || !en) begin
         cnt_q <= 8'h00;
         refresh_pulse <= 1'b0;
      end else begin
         refresh_pulse <= (cnt_q == gap);
         cnt_q <= (cnt_q == gap) ? 8'h00 : cnt_q + 8'h01;
      end
   end
endmodule // wdcu_host

// >>> test/wdcu_top_bench.sv
// Self-checking bench for the watchdog configuration and unlock block
`timescale 1ns/1ps
module wdcu_top_bench;
   import wdcu_pkg::*;
   logic clk, rst_n, refresh_pulse, ext_fault, phase_gate_enable, host_en;
   logic gate_drv, uv_det, fault_pin, dith_on, wd_rst, flash, cfg_mode, irq;
   logic [7:0] rdata, host_gap, d;
   wdcu_bus_s bus; // Register bus request
   int miscompares = 0;
   int checks_done = 0;
   // Short tick (4 clocks) keeps every timeout the bench selects to a few hundred cycles
   wdcu_top #(.TICK_CYCLES(4)) dut_u (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
      .refresh_pulse(refresh_pulse), .ext_fault(ext_fault),
      .phase_gate_enable(phase_gate_enable), .phase_gate_drive(gate_drv),
      .source_node_undervoltage_detect(uv_det), .fault_flag_pin(fault_pin),
      .spread_spectrum_on(dith_on), .wd_reset_out(wd_rst), .flash_mode(flash),
      .config_mode(cfg_mode), .irq(irq));
   wdcu_host host_u (.clk(clk), .rst_n(rst_n), .en(host_en), .gap(host_gap),
      .refresh_pulse(refresh_pulse));
   // Clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One-cycle write; returns just after the edge so the written state has settled
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
      #1;
   endtask
   // Read; data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Bounded wait for a level, sampled mid-cycle where registered outputs have settled
   task automatic wait_sig(ref logic s, input logic v, input int n);
      while (s !== v && n > 0) begin
         @(negedge clk);
         n--;
      end
      check(8'(s), 8'(v));
   endtask
   // Full three-word unlock
   task automatic key(input logic [7:0] w3);
      wr(WDCU_OFS_KEY, WDCU_KEY_FIRST);
      wr(WDCU_OFS_KEY, WDCU_KEY_SECOND);
      wr(WDCU_OFS_KEY, w3);
   endtask
   // Reset values of registers and pins
   task automatic t_reset();
      for (int a = 8; a < 12; a++) begin
         rd(8'(a), d);
         check(d, 8'h00);
      end
      check({2'b00, fault_pin, dith_on, flash, cfg_mode, wd_rst, irq}, 8'h30);
   endtask
   // Field storage and the pins that follow them
   task automatic t_cfg();
      wr(WDCU_OFS_QA, 8'hFF);
      rd(WDCU_OFS_QA, d);
      check(d, 8'h3F);
      wr(WDCU_OFS_CFG0, 8'hFF);
      wr(WDCU_OFS_CFG1, 8'hFF);
      rd(WDCU_OFS_CFG0, d);
      check(d, 8'hFF);
      wr(WDCU_OFS_CFG0, 8'h00);
      rd(WDCU_OFS_CFG1, d);
      check(d, 8'h3F);
      check({uv_det, dith_on}, 8'h02);
      wr(WDCU_OFS_CFG1, 8'h00);
      check({uv_det, dith_on}, 8'h01);
      wr(WDCU_OFS_STAT, 8'hFF);
   endtask
   // Every action word, then broken sequences
   task automatic t_key();
      logic [7:0] acts[4] = '{WDCU_KEY_FLASH, WDCU_KEY_CONFIG, WDCU_KEY_DISABLE,
         WDCU_KEY_RESTART};
      for (int k = 0; k < 4; k++) begin
         key(acts[k]);
         rd(WDCU_OFS_STAT, d);
         check(d, 8'h01);
         wr(WDCU_OFS_STAT, 8'h01);
      end
      check({flash, cfg_mode}, 8'h03);
      wr(WDCU_OFS_KEY, WDCU_KEY_FIRST);
      rd(WDCU_OFS_STATE, d);
      check(d & 8'hC0, 8'h40);
      wr(WDCU_OFS_KEY, 8'h55);
      wr(WDCU_OFS_KEY, WDCU_KEY_SECOND);
      rd(WDCU_OFS_STATE, d);
      check(d & 8'hC0, 8'h00);
      key(8'hC0);
      rd(WDCU_OFS_STAT, d);
      check(d, 8'h02);
      wr(WDCU_OFS_STAT, 8'hFF);
   endtask
   // Serviced watchdog, missed refresh, fault, interrupt and allowance
   task automatic t_wd();
      int highs = 0;
      wr(WDCU_OFS_MASK, 8'h08);
      host_en <= 1'b1;
      wr(WDCU_OFS_CFG0, 8'h43);
      repeat (400) @(posedge clk) highs += int'(wd_rst === 1'b1);
      check(8'(highs), 8'h00);
      host_en <= 1'b0;
      wait_sig(wd_rst, 1'b1, 100);
      // The pin is registered from the fault latch, so it trails the reset pulse by a cycle
      @(negedge clk);
      check({irq, fault_pin}, 8'h02);
      wait_sig(wd_rst, 1'b0, 60);
      wr(WDCU_OFS_STAT, 8'h08);
      check(8'(irq), 8'h00);
      key(WDCU_KEY_RESTART);
      wr(WDCU_OFS_CFG0, 8'h53);
      repeat (80) @(posedge clk);
      check(8'(wd_rst), 8'h00);
      rd(WDCU_OFS_STATE, d);
      check(d & 8'h3C, 8'h08);
      wait_sig(wd_rst, 1'b1, 100);
      wr(WDCU_OFS_CFG0, 8'h00);
      key(WDCU_KEY_RESTART);
      wr(WDCU_OFS_STAT, 8'hFF);
   endtask
   // Answers refresh in question mode, then a too-early window refresh faults
   task automatic t_qa();
      wr(WDCU_OFS_CFG0, 8'h83);
      repeat (6) begin
         repeat (40) @(posedge clk);
         wr(WDCU_OFS_QA, 8'h2A);
      end
      rd(WDCU_OFS_STATE, d);
      check(d & 8'h3C, 8'h00);
      wr(WDCU_OFS_CFG0, 8'h43);
      host_gap <= 8'd3;
      host_en <= 1'b1;
      repeat (12) @(posedge clk);
      host_en <= 1'b0;
      rd(WDCU_OFS_STAT, d);
      check(d & 8'h0C, 8'h0C);
      check(8'(irq), 8'h01);
      wr(WDCU_OFS_CFG0, 8'h00);
      key(WDCU_KEY_RESTART);
      wr(WDCU_OFS_STAT, 8'hFF);
   endtask
   // Gate delay in both roles, then fault pin functions
   task automatic t_pins();
      phase_gate_enable <= 1'b1;
      repeat (70) @(posedge clk);
      check(8'(gate_drv), 8'h00);
      wait_sig(gate_drv, 1'b1, 30);
      wr(WDCU_OFS_CFG1, 8'h20);
      phase_gate_enable <= 1'b0;
      repeat (4) @(posedge clk);
      check(8'(gate_drv), 8'h01);
      wait_sig(gate_drv, 1'b0, 16);
      ext_fault <= 1'b1;
      wait_sig(fault_pin, 1'b0, 4);
      wr(WDCU_OFS_CFG1, 8'h10);
      wait_sig(fault_pin, 1'b1, 100);
      wait_sig(fault_pin, 1'b0, 100);
      ext_fault <= 1'b0;
   endtask
   // Verdict and end of run
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // Hang guard, well past the expected run of under 1500 cycles
   initial begin
      #(40 * 20000);
      miscompares++;
      give_verdict();
   end
   // Main sequence
   initial begin
      rst_n = 1'b0;
      bus = '0;
      ext_fault = 1'b0;
      phase_gate_enable = 1'b0;
      host_en = 1'b0;
      host_gap = 8'd47;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_cfg();
      t_key();
      t_wd();
      t_qa();
      t_pins();
      give_verdict();
   end
endmodule // wdcu_top_bench
